// File: hw/ccpl_cache.v
/*
  cache directory and policy engine: instruction, data and mini caches
  with per-region policy, round-robin replacement and per-way locking.
  assumes line data lives outside; the memory side answers each request
  with a one-cycle ack; core and memory logic share clk_i.
*/
// Chosen here: the Wishbone register port and the address map.
// Functional notes
// - separate caches; icache filled by fetches and lock commands only
// - icache simply enabled or disabled
// - victims chosen by round-robin pointer
// - icache 32 sets, 1024-byte set period
// - locked icache lines never replaced
// - uncached regions with or without coalescing
// - mini cache coalesces; three allocate policies
// - data cache coalesces; three allocate policies
// - xcb all zero: uncached, reads go out
// - read-allocate write miss allocates nothing
// - write-through stores also go to bus
// - policies changeable at run time
// - locked data lines act as RAM
// - data locks per way, 32 ways
// - consecutive lines map to consecutive sets
// - 32-byte aligned lines
// - mini cache has two ways
`timescale 1ns/1ns
`include "ccpl_consts.vh"
module ccpl_cache (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        req_valid_i,
  output wire        req_ready_o,
  input  wire        req_fetch_i,
  input  wire        req_we_i,
  input  wire [31:0] req_addr_i,
  input  wire [2:0]  req_xcb_i,
  output wire        rsp_valid_o,
  output wire        rsp_hit_o,
  output wire [1:0]  rsp_cache_o,
  output wire [4:0]  rsp_way_o,
  output wire        mem_req_o,
  output wire [1:0]  mem_op_o,
  output wire [31:0] mem_addr_o,
  output wire        mem_coalesce_o,
  input  wire        mem_ack_i
);
  localparam S_IDLE = 3'h0;
  localparam S_LOOK = 3'h1;
  localparam S_WB   = 3'h2;
  localparam S_FILL = 3'h3;
  localparam S_WORD = 3'h4;
  localparam S_DONE = 3'h5;
  localparam J_CORE  = 2'h0;
  localparam J_LOCK  = 2'h1;
  localparam J_CLEAN = 2'h2;

  // software side
  reg  [3:0]  ctrl_r;
  reg         lock_pend_r;
  reg  [31:0] lock_cmd_r;
  reg         clean_pend_r;
  reg  [31:0] clean_cmd_r;
  reg         lock_fail_r;
  reg  [31:0] hits_r;
  reg  [31:0] miss_r;
  reg         ack_r;
  reg  [31:0] rdat_r;
  reg  [31:0] rdat_nxt;

  // engine
  reg  [2:0]  st_r;
  reg  [1:0]  job_r;
  reg  [31:0] addr_r;
  reg         we_r;
  reg  [1:0]  cache_r;
  reg  [1:0]  pol_r;
  reg         coal_r;
  reg         unlock_r;
  reg  [4:0]  way_r;
  reg         hit_r;
  reg  [1:0]  op_r;
  reg  [31:0] maddr_r;
  reg         rsp_valid_r;
  reg  [1:0]  rsp_cache_r;

  // directory: index is {cache, set}, entry is {index, way}
  reg  [21:0] tag_mem [0:4095];
  reg  [31:0] val_r   [0:127];
  reg  [31:0] dirty_r [0:127];
  reg  [31:0] lck_r   [0:127];
  reg  [4:0]  rr_r    [0:127];

  reg  [1:0]  cls_cache;
  reg  [1:0]  cls_pol;
  reg         cls_coal;
  reg         hit_c;
  reg  [4:0]  hway_c;
  integer     w;
  integer     i;

  wire        acc   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr    = acc & wb_we_i;
  wire        idle  = (st_r == S_IDLE);
  wire        take_lock  = idle & lock_pend_r;
  wire        take_clean = idle & ~lock_pend_r & clean_pend_r;
  wire        take_core  = idle & ~lock_pend_r & ~clean_pend_r & req_valid_i;
  wire [6:0]  idx   = {cache_r, addr_r[`CCPL_SET_MSB:`CCPL_SET_LSB]};
  wire [21:0] tag   = addr_r[31:`CCPL_TAG_LSB];
  wire [31:0] lmask = lck_r[idx] |
                      ((cache_r == `CCPL_C_MINI) ? `CCPL_MINI_PAD
                                                 : 32'h0000_0000);
  wire [4:0]  vway;
  wire        vfound;
  wire        vdirty = val_r[idx][vway] & dirty_r[idx][vway];
  wire [31:0] line_a = {addr_r[31:`CCPL_LINE_LSB], 5'h00};
  wire [31:0] vict_a = {tag_mem[{idx, vway}], idx[4:0], 5'h00};
  wire        look  = (st_r == S_LOOK);
  wire        ev_hit  = look & (job_r == J_CORE) &
                        (cache_r != `CCPL_C_UNC) & hit_c;
  wire        ev_miss = look & (job_r == J_CORE) &
                        (cache_r != `CCPL_C_UNC) & ~hit_c;
  wire        ev_fail = look & (job_r == J_LOCK) & ~hit_c &
                        ~unlock_r & ~vfound;

  // locked ways are masked before the pointer scan
  ccpl_rr_pick #(
    .WAYS (`CCPL_WAYS),
    .PW   (`CCPL_WAY_W)
  ) u_pick (
    .lock_i  (lmask),
    .ptr_i   (rr_r[idx]),
    .way_o   (vway),
    .found_o (vfound)
  );

  // region classification from the page attribute flags
  always @* begin
    cls_cache = `CCPL_C_UNC;
    cls_pol   = `CCPL_POL_WB_RA;
    cls_coal  = req_xcb_i[0];
    if (req_fetch_i) begin
      if (ctrl_r[`CCPL_CTRL_IC_EN] && req_xcb_i[1])
        cls_cache = `CCPL_C_IC;
    end else if (req_xcb_i[1] && ctrl_r[`CCPL_CTRL_DC_EN]) begin
      cls_coal = 1'b1;
      if (req_xcb_i == 3'h6) begin
        cls_cache = `CCPL_C_MINI;
        cls_pol   = ctrl_r[`CCPL_CTRL_MP_MSB:`CCPL_CTRL_MP_LSB];
        if (cls_pol == 2'h3)
          cls_pol = `CCPL_POL_WB_RA;
      end else begin
        cls_cache = `CCPL_C_DC;
        if (!req_xcb_i[0])
          cls_pol = `CCPL_POL_WT_RA;
        else if (req_xcb_i[2])
          cls_pol = `CCPL_POL_WB_RWA;
      end
    end else if (req_xcb_i[1]) begin
      cls_coal = 1'b1;
    end
  end

  // tag compare over all ways of the indexed set
  always @* begin
    hit_c  = 1'b0;
    hway_c = 5'h00;
    for (w = 0; w < `CCPL_WAYS; w = w + 1) begin
      if (val_r[idx][w] && tag_mem[{idx, w[4:0]}] == tag) begin
        hit_c  = 1'b1;
        hway_c = w[4:0];
      end
    end
  end

  // tag store: written only when a fill completes
  always @(posedge clk_i) begin
    if (st_r == S_FILL && mem_ack_i)
      tag_mem[{idx, way_r}] <= tag;
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r        <= S_IDLE;
      job_r       <= J_CORE;
      addr_r      <= 32'h0000_0000;
      we_r        <= 1'b0;
      cache_r     <= `CCPL_C_UNC;
      pol_r       <= `CCPL_POL_WB_RA;
      coal_r      <= 1'b0;
      unlock_r    <= 1'b0;
      way_r       <= 5'h00;
      hit_r       <= 1'b0;
      op_r        <= `CCPL_OP_WRD;
      maddr_r     <= 32'h0000_0000;
      rsp_valid_r <= 1'b0;
      rsp_cache_r <= `CCPL_C_UNC;
      for (i = 0; i < 128; i = i + 1) begin
        val_r[i]   <= 32'h0000_0000;
        dirty_r[i] <= 32'h0000_0000;
        lck_r[i]   <= 32'h0000_0000;
        rr_r[i]    <= 5'h00;
      end
    end else begin
      rsp_valid_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          hit_r <= 1'b0;
          if (take_lock) begin
            job_r    <= J_LOCK;
            addr_r   <= lock_cmd_r;
            we_r     <= 1'b0;
            cache_r  <= (lock_cmd_r[1:0] == `CCPL_C_UNC) ? `CCPL_C_DC
                        : lock_cmd_r[`CCPL_LCK_TGT_MSB:`CCPL_LCK_TGT_LSB];
            unlock_r <= lock_cmd_r[`CCPL_LCK_UNLOCK];
            coal_r   <= 1'b1;
            st_r     <= S_LOOK;
          end else if (take_clean) begin
            job_r    <= J_CLEAN;
            addr_r   <= clean_cmd_r;
            we_r     <= 1'b0;
            cache_r  <= clean_cmd_r[`CCPL_CLN_MINI] ? `CCPL_C_MINI
                                                    : `CCPL_C_DC;
            unlock_r <= 1'b0;
            coal_r   <= 1'b1;
            st_r     <= S_LOOK;
          end else if (take_core) begin
            job_r    <= J_CORE;
            addr_r   <= req_addr_i;
            we_r     <= req_we_i & ~req_fetch_i;
            cache_r  <= cls_cache;
            pol_r    <= cls_pol;
            coal_r   <= cls_coal;
            unlock_r <= 1'b0;
            st_r     <= S_LOOK;
          end
        end
        S_LOOK: begin
          way_r <= vway;
          hit_r <= hit_c;
          if (job_r == J_CORE && cache_r == `CCPL_C_UNC) begin
            op_r    <= we_r ? `CCPL_OP_WWR : `CCPL_OP_WRD;
            maddr_r <= addr_r;
            st_r    <= S_WORD;
          end else if (job_r == J_CLEAN) begin
            way_r <= hway_c;
            if (hit_c && dirty_r[idx][hway_c]) begin
              op_r    <= `CCPL_OP_LWR;
              maddr_r <= line_a;
              st_r    <= S_WB;
            end else begin
              st_r <= S_DONE;
            end
          end else if (hit_c) begin
            // locked lines hit here like any other: no miss, no eviction
            way_r <= hway_c;
            if (job_r == J_LOCK) begin
              lck_r[idx][hway_c] <= ~unlock_r;
              st_r <= S_DONE;
            end else if (we_r && pol_r == `CCPL_POL_WT_RA) begin
              op_r    <= `CCPL_OP_WWR;
              maddr_r <= addr_r;
              st_r    <= S_WORD;
            end else begin
              if (we_r)
                dirty_r[idx][hway_c] <= 1'b1;
              st_r <= S_DONE;
            end
          end else if (job_r == J_LOCK && (unlock_r || !vfound)) begin
            st_r <= S_DONE;
          end else if (we_r && pol_r != `CCPL_POL_WB_RWA) begin
            op_r    <= `CCPL_OP_WWR;
            maddr_r <= addr_r;
            st_r    <= S_WORD;
          end else if (!vfound) begin
            // whole set locked: serve the access uncached
            op_r    <= we_r ? `CCPL_OP_WWR : `CCPL_OP_WRD;
            maddr_r <= addr_r;
            st_r    <= S_WORD;
          end else if (vdirty) begin
            op_r    <= `CCPL_OP_LWR;
            maddr_r <= vict_a;
            st_r    <= S_WB;
          end else begin
            op_r    <= `CCPL_OP_LRD;
            maddr_r <= line_a;
            st_r    <= S_FILL;
          end
        end
        S_WB: begin
          if (mem_ack_i) begin
            dirty_r[idx][way_r] <= 1'b0;
            if (job_r == J_CLEAN) begin
              st_r <= S_DONE;
            end else begin
              op_r    <= `CCPL_OP_LRD;
              maddr_r <= line_a;
              st_r    <= S_FILL;
            end
          end
        end
        S_FILL: begin
          if (mem_ack_i) begin
            val_r[idx][way_r]   <= 1'b1;
            dirty_r[idx][way_r] <= we_r;
            lck_r[idx][way_r]   <= (job_r == J_LOCK);
            if (cache_r == `CCPL_C_MINI)
              rr_r[idx] <= {4'h0, ~way_r[0]};
            else
              rr_r[idx] <= way_r + 5'h01;
            st_r <= S_DONE;
          end
        end
        S_WORD: begin
          if (mem_ack_i)
            st_r <= S_DONE;
        end
        S_DONE: begin
          rsp_valid_r <= (job_r == J_CORE);
          rsp_cache_r <= cache_r;
          st_r        <= S_IDLE;
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  // register read mux; unmapped offsets read zero
  always @* begin
    case (wb_adr_i)
      `CCPL_ADR_CTRL:  rdat_nxt = {28'h0000000, ctrl_r};
      `CCPL_ADR_LOCK:  rdat_nxt = lock_cmd_r;
      `CCPL_ADR_CLEAN: rdat_nxt = clean_cmd_r;
      `CCPL_ADR_STAT:  rdat_nxt = {28'h0000000, clean_pend_r, lock_pend_r,
                                   lock_fail_r, ~idle};
      `CCPL_ADR_HITS:  rdat_nxt = hits_r;
      `CCPL_ADR_MISS:  rdat_nxt = miss_r;
      default:         rdat_nxt = 32'h0000_0000;
    endcase
  end

  // wishbone slave: one wait state, write lands at the acking edge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r        <= 1'b0;
      rdat_r       <= 32'h0000_0000;
      ctrl_r       <= `CCPL_CTRL_RST;
      lock_pend_r  <= 1'b0;
      lock_cmd_r   <= 32'h0000_0000;
      clean_pend_r <= 1'b0;
      clean_cmd_r  <= 32'h0000_0000;
      lock_fail_r  <= 1'b0;
      hits_r       <= 32'h0000_0000;
      miss_r       <= 32'h0000_0000;
    end else begin
      ack_r <= acc;
      if (acc && !wb_we_i)
        rdat_r <= rdat_nxt;
      if (wr && wb_adr_i == `CCPL_ADR_CTRL && wb_sel_i[0])
        ctrl_r <= wb_dat_i[3:0];
      // a command written as one is taken is kept, not lost
      if (wr && wb_adr_i == `CCPL_ADR_LOCK && wb_sel_i == 4'hf) begin
        lock_cmd_r  <= wb_dat_i;
        lock_pend_r <= 1'b1;
      end else if (take_lock) begin
        lock_pend_r <= 1'b0;
      end
      if (wr && wb_adr_i == `CCPL_ADR_CLEAN && wb_sel_i == 4'hf) begin
        clean_cmd_r  <= wb_dat_i;
        clean_pend_r <= 1'b1;
      end else if (take_clean) begin
        clean_pend_r <= 1'b0;
      end
      if (ev_fail)
        lock_fail_r <= 1'b1;
      else if (wr && wb_adr_i == `CCPL_ADR_STAT && wb_sel_i[0] &&
               wb_dat_i[`CCPL_STAT_FAIL])
        lock_fail_r <= 1'b0;
      if (ev_hit)
        hits_r <= hits_r + 32'h0000_0001;
      if (ev_miss)
        miss_r <= miss_r + 32'h0000_0001;
    end
  end

  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = rdat_r;
  assign req_ready_o    = idle & ~lock_pend_r & ~clean_pend_r;
  assign rsp_valid_o    = rsp_valid_r;
  assign rsp_hit_o      = hit_r;
  assign rsp_cache_o    = rsp_cache_r;
  assign rsp_way_o      = way_r;
  assign mem_req_o      = (st_r == S_WB) | (st_r == S_FILL) |
                          (st_r == S_WORD);
  assign mem_op_o       = op_r;
  assign mem_addr_o     = maddr_r;
  assign mem_coalesce_o = coal_r;
endmodule

// File: hw/ccpl_consts.vh
/*
  constants of the cache policy, lock and replacement block: register
  offsets, field positions, reset values, encodings and geometry.
  assumes inclusion by bare name from the design files.
*/
`ifndef CCPL_CONSTS_VH
`define CCPL_CONSTS_VH

`define CCPL_ADR_CTRL    8'h00
`define CCPL_ADR_LOCK    8'h04
`define CCPL_ADR_CLEAN   8'h08
`define CCPL_ADR_STAT    8'h0c
`define CCPL_ADR_HITS    8'h10
`define CCPL_ADR_MISS    8'h14

`define CCPL_CTRL_IC_EN  0
`define CCPL_CTRL_DC_EN  1
`define CCPL_CTRL_MP_LSB 2
`define CCPL_CTRL_MP_MSB 3
`define CCPL_CTRL_RST    4'h0

`define CCPL_LCK_TGT_LSB 0
`define CCPL_LCK_TGT_MSB 1
`define CCPL_LCK_UNLOCK  2
`define CCPL_CLN_MINI    0

`define CCPL_STAT_BUSY   0
`define CCPL_STAT_FAIL   1
`define CCPL_STAT_LPEND  2
`define CCPL_STAT_CPEND  3

`define CCPL_C_IC        2'h0
`define CCPL_C_DC        2'h1
`define CCPL_C_MINI      2'h2
`define CCPL_C_UNC       2'h3

`define CCPL_POL_WB_RA   2'h0
`define CCPL_POL_WT_RA   2'h1
`define CCPL_POL_WB_RWA  2'h2

`define CCPL_OP_LRD      2'h0
`define CCPL_OP_LWR      2'h1
`define CCPL_OP_WRD      2'h2
`define CCPL_OP_WWR      2'h3

`define CCPL_LINE_LSB    5
`define CCPL_SET_LSB     5
`define CCPL_SET_MSB     9
`define CCPL_TAG_LSB     10
`define CCPL_WAYS        32
`define CCPL_WAY_W       5
`define CCPL_MINI_PAD    32'hffff_fffc

`endif

// File: hw/ccpl_rr_pick.v
/*
  round-robin victim picker: first unlocked way at or after the pointer.
  assumes a power-of-two way count so the sum wraps by truncation.
*/
`timescale 1ns/1ns
module ccpl_rr_pick #(
  parameter WAYS = 32,
  parameter PW   = 5
) (
  input  wire [WAYS-1:0] lock_i,
  input  wire [PW-1:0]   ptr_i,
  output reg  [PW-1:0]   way_o,
  output reg             found_o
);
  reg [PW-1:0] cand;
  integer      k;

  // scan downward so the nearest unlocked way wins
  always @* begin
    way_o   = ptr_i;
    found_o = 1'b0;
    cand    = ptr_i;
    for (k = WAYS - 1; k >= 0; k = k - 1) begin
      cand = ptr_i + k[PW-1:0];
      if (!lock_i[cand]) begin
        way_o   = cand;
        found_o = 1'b1;
      end
    end
  end
endmodule

// File: test/ccpl_cache_monitor.sv
/*
  port checks of the cache block.
  assumes one clock and async active-low reset; bound at the foot.
*/
`timescale 1ns/1ns
`include "ccpl_consts.vh"
module ccpl_cache_monitor (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        req_valid_i,
  input wire        req_ready_o,
  input wire        req_fetch_i,
  input wire        req_we_i,
  input wire [2:0]  req_xcb_i,
  input wire        rsp_valid_o,
  input wire        rsp_hit_o,
  input wire [1:0]  rsp_cache_o,
  input wire        mem_req_o,
  input wire [1:0]  mem_op_o,
  input wire [31:0] mem_addr_o,
  input wire        mem_coalesce_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  reg       fetch_r;
  reg       st_we_r;
  reg       busy_r;
  reg [2:0] xcb_r;
  // busy spans take to answer so lock fills are never blamed on a store
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fetch_r <= 1'b0;
      st_we_r <= 1'b0;
      busy_r  <= 1'b0;
      xcb_r   <= 3'h0;
    end else if (req_valid_i && req_ready_o) begin
      fetch_r <= req_fetch_i;
      st_we_r <= req_we_i;
      busy_r  <= 1'b1;
      xcb_r   <= req_xcb_i;
    end else if (rsp_valid_o) begin
      busy_r <= 1'b0;
    end
  end
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_fill;
    mem_req_o && mem_op_o == `CCPL_OP_LRD;
  endsequence
  sequence s_wwr;
    mem_req_o && mem_op_o == `CCPL_OP_WWR;
  endsequence
  AST_WB_ACK:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  AST_RSP_BOUND:
    assert property (s_take |-> ##[3:60] rsp_valid_o)
    else $error("no answer");
  AST_FETCH_IC:
    assert property (rsp_valid_o && fetch_r |-> rsp_cache_o ==
      `CCPL_C_IC || rsp_cache_o == `CCPL_C_UNC) else $error("fetch");
  AST_DATA_NOT_IC:
    assert property (rsp_valid_o && !fetch_r |->
      rsp_cache_o != `CCPL_C_IC) else $error("data in icache");
  AST_UNC_RSP:
    assert property (rsp_valid_o && !fetch_r && !xcb_r[1] |->
      rsp_cache_o == `CCPL_C_UNC && !rsp_hit_o) else $error("unc rsp");
  AST_UNC_READ:
    assert property (s_take ##0 (!req_fetch_i && !req_we_i &&
      !req_xcb_i[1]) |-> ##[1:20] (mem_req_o && mem_op_o ==
      `CCPL_OP_WRD)) else $error("unc read not sent");
  AST_UNC_COAL:
    assert property (s_wwr ##0 (!fetch_r && !xcb_r[1]) |->
      mem_coalesce_o == xcb_r[0]) else $error("unc coalesce");
  AST_CACHED_COAL:
    assert property (s_wwr ##0 (!fetch_r && xcb_r[1]) |->
      mem_coalesce_o) else $error("cached write not coalesced");
  AST_WT_STORE:
    assert property (s_take ##0 (!req_fetch_i && req_we_i &&
      req_xcb_i == 3'h2) |-> ##[1:40] s_wwr) else $error("wt store");
  AST_RA_NO_FILL:
    assert property (s_fill |-> !(busy_r && st_we_r && !fetch_r &&
      xcb_r[2:1] == 2'h1)) else $error("ra fill");
  AST_FILL_ALIGN:
    assert property (mem_req_o && !mem_op_o[1] |->
      mem_addr_o[4:0] == 5'h00) else $error("line unaligned");
  cover property (s_fill);
endmodule
bind ccpl_cache ccpl_cache_monitor u_mon (.clk_i(clk_i),
  .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .req_fetch_i(req_fetch_i),
  .req_we_i(req_we_i), .req_xcb_i(req_xcb_i), .rsp_valid_o(rsp_valid_o),
  .rsp_hit_o(rsp_hit_o), .rsp_cache_o(rsp_cache_o),
  .mem_req_o(mem_req_o), .mem_op_o(mem_op_o), .mem_addr_o(mem_addr_o),
  .mem_coalesce_o(mem_coalesce_o));

// File: test/ccpl_mem_model.sv
/*
  memory-side partner: acks each request after 0..3 idle cycles,
  rotating, and counts fills, line writes and word writes.
  assumes the block holds mem_req_o and its op until the ack edge.
*/
`timescale 1ns/1ns
`include "ccpl_consts.vh"
module ccpl_mem_model (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       mem_req_i,
  input  wire [1:0] mem_op_i,
  output reg        mem_ack_o,
  output reg  [7:0] fills_o,
  output reg  [7:0] lws_o,
  output reg  [7:0] wws_o
);
  reg [1:0] lat_r;
  reg [1:0] cnt_r;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_ack_o <= 1'b0;
      lat_r     <= 2'h0;
      cnt_r     <= 2'h0;
      fills_o   <= 8'h00;
      lws_o     <= 8'h00;
      wws_o     <= 8'h00;
    end else if (mem_ack_o) begin
      mem_ack_o <= 1'b0;
      lat_r     <= lat_r + 2'h1;
      cnt_r     <= lat_r + 2'h1;
    end else if (mem_req_i && cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end else if (mem_req_i) begin
      mem_ack_o <= 1'b1;
      fills_o   <= fills_o + {7'h0, mem_op_i == `CCPL_OP_LRD};
      lws_o     <= lws_o + {7'h0, mem_op_i == `CCPL_OP_LWR};
      wws_o     <= wws_o + {7'h0, mem_op_i == `CCPL_OP_WWR};
    end
  end
endmodule

// File: test/test_ccpl_cache.sv
/*
  self-checking bench: registers, fetch, replacement, locking,
  allocate policies, mini cache and random traffic.
  assumes the memory model acks every request.
*/
`timescale 1ns/1ns
`include "ccpl_consts.vh"
module test_ccpl_cache;
  reg         clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [7:0]  wb_adr_i, f0, l0, w0;
  reg  [3:0]  wb_sel_i, ctl;
  reg  [31:0] wb_dat_i, req_addr_i, q, b;
  reg         req_valid_i, req_fetch_i, req_we_i;
  reg  [2:0]  req_xcb_i;
  wire [31:0] wb_dat_o, mem_addr_o;
  wire        wb_ack_o, req_ready_o, rsp_valid_o, rsp_hit_o;
  wire        mem_req_o, mem_coalesce_o, mem_ack_i;
  wire [1:0]  rsp_cache_o, mem_op_o;
  wire [4:0]  rsp_way_o;
  wire [7:0]  fills, lws, wws;
  integer     seed, r, k, failures, check_count, cycles;
  ccpl_cache DUT (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_fetch_i(req_fetch_i),
    .req_we_i(req_we_i), .req_addr_i(req_addr_i), .req_xcb_i(req_xcb_i),
    .rsp_valid_o(rsp_valid_o), .rsp_hit_o(rsp_hit_o),
    .rsp_cache_o(rsp_cache_o), .rsp_way_o(rsp_way_o),
    .mem_req_o(mem_req_o), .mem_op_o(mem_op_o), .mem_addr_o(mem_addr_o),
    .mem_coalesce_o(mem_coalesce_o), .mem_ack_i(mem_ack_i));
  ccpl_mem_model MEM (.clk_i(clk_i), .resetn_i(resetn_i),
    .mem_req_i(mem_req_o), .mem_op_i(mem_op_o), .mem_ack_o(mem_ack_i),
    .fills_o(fills), .lws_o(lws), .wws_o(wws));
  always #4 clk_i = ~clk_i;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input w, input [7:0] a, input [31:0] d,
                    output [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // lock and clean go over the register bus, never a cached fetch
  task automatic cmd(input [7:0] a, input [31:0] d);
    wb(1'b1, a, d, q);
    q = 32'hd;
    while ((q & 32'hd) != 0) wb(1'b0, `CCPL_ADR_STAT, 0, q);
  endtask
  task automatic core(input f, input w, input [31:0] a, input [2:0] x);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_fetch_i <= f;
    req_we_i    <= w;
    req_addr_i  <= a;
    req_xcb_i   <= x;
    @(posedge clk_i);
    while (req_ready_o !== 1'b1) @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    while (rsp_valid_o !== 1'b1) @(posedge clk_i);
  endtask
  task automatic bus(input [7:0] df, input [7:0] dl, input [7:0] dw);
    chk({8'h0, fills - f0, lws - l0, wws - w0}, {8'h0, df, dl, dw});
    f0 = fills;
    l0 = lws;
    w0 = wws;
  endtask
  function automatic [1:0] exp_c(input f, input [2:0] x, input [1:0] en);
    if (f)
      exp_c = (en[0] && x[1]) ? `CCPL_C_IC : `CCPL_C_UNC;
    else if (!x[1] || !en[1])
      exp_c = `CCPL_C_UNC;
    else
      exp_c = (x == 3'h6) ? `CCPL_C_MINI : `CCPL_C_DC;
  endfunction
  initial begin
    seed = 78394;
    {failures, check_count, cycles} = 0;
    {clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = 0;
    {wb_dat_i, req_valid_i, req_fetch_i, req_we_i, req_addr_i} = 0;
    req_xcb_i = 3'h0;
    wb_sel_i = 4'hf;
    {f0, l0, w0} = 0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    chk(req_ready_o, 1);
    wb(1'b0, `CCPL_ADR_CTRL, 0, q);
    chk(q, `CCPL_CTRL_RST);
    wb(1'b1, 8'h20, 32'hffff_ffff, q);
    wb(1'b0, 8'h20, 0, q);
    chk(q, 0);
    wb(1'b1, `CCPL_ADR_HITS, 32'h5, q);
    wb(1'b0, `CCPL_ADR_HITS, 0, q);
    chk(q, 0);
    $display("test regs done");
    core(1'b1, 1'b0, 32'h1040, 3'h2);
    chk(rsp_cache_o, `CCPL_C_UNC);
    ctl = 4'h3;
    wb(1'b1, `CCPL_ADR_CTRL, {28'h0, ctl}, q);
    for (k = 0; k < 2; k = k + 1) begin
      core(1'b1, 1'b0, 32'h1040, 3'h2);
      chk({rsp_hit_o, rsp_cache_o}, {k[0], `CCPL_C_IC});
    end
    core(1'b0, 1'b0, 32'h1040, 3'h3);
    chk({rsp_hit_o, rsp_cache_o}, {1'b0, `CCPL_C_DC});
    $display("test enable done");
    b = 32'h0002_0000;
    for (k = 0; k < 33; k = k + 1) begin
      core(1'b1, 1'b0, b + k * 1024, 3'h2);
      chk({rsp_hit_o, rsp_way_o}, k % 32);
    end
    core(1'b1, 1'b0, b + 1024, 3'h2);
    chk(rsp_hit_o, 1);
    core(1'b1, 1'b0, b, 3'h2);
    chk(rsp_hit_o, 0);
    core(1'b1, 1'b0, b + 32, 3'h2);
    chk({rsp_hit_o, rsp_way_o}, 0);
    $display("test replace done");
    cmd(`CCPL_ADR_LOCK, b + 2048);
    for (k = 3; k < 35; k = k + 1)
      core(1'b1, 1'b0, b + k * 1024, 3'h2);
    core(1'b1, 1'b0, b + 2048, 3'h2);
    chk({rsp_hit_o, rsp_way_o}, 32'h22);
    b = 32'h0010_0000;
    {f0, l0, w0} = {fills, lws, wws};
    for (k = 0; k < 3; k = k + 1)
      cmd(`CCPL_ADR_LOCK, b + k * 1024 + 1);
    wb(1'b0, `CCPL_ADR_STAT, 0, q);
    chk(q & 32'h2, 0);
    bus(8'h3, 8'h0, 8'h0);
    for (k = 0; k < 3; k = k + 1) begin
      core(1'b0, 1'b0, b + k * 1024, 3'h3);
      chk(rsp_hit_o, 1);
    end
    bus(8'h0, 8'h0, 8'h0);
    for (k = 3; k < 64; k = k + 1) begin
      core(1'b0, 1'b0, b + (k % 32 + k / 32 * 3) * 1024, 3'h3);
      // ways 0..2 locked: lines 32..34 land in ways 3..5
      r = k - (k < 32 ? 0 : (k < 61 ? 29 : 58));
      chk({rsp_hit_o, rsp_way_o}, {k > 31 && k < 61, r[4:0]});
    end
    $display("test lock done");
    {f0, l0, w0} = {fills, lws, wws};
    b = 32'h0020_0080;
    core(1'b0, 1'b1, b, 3'h2);
    bus(8'h0, 8'h0, 8'h1);
    core(1'b0, 1'b1, b + 32, 3'h3);
    bus(8'h0, 8'h0, 8'h1);
    core(1'b0, 1'b1, b + 64, 3'h7);
    bus(8'h1, 8'h0, 8'h0);
    core(1'b0, 1'b1, b + 64, 3'h7);
    chk(rsp_hit_o, 1);
    cmd(`CCPL_ADR_CLEAN, b + 64);
    cmd(`CCPL_ADR_CLEAN, b + 64);
    bus(8'h0, 8'h1, 8'h0);
    $display("test policy done");
    b = 32'h0030_0000;
    for (k = 0; k < 4; k = k + 1) begin
      core(1'b0, 1'b0, b + (k % 3) * 1024, 3'h6);
      chk({rsp_hit_o, rsp_cache_o, rsp_way_o[4:1]}, 32'h20);
    end
    ctl = 4'h7;
    wb(1'b1, `CCPL_ADR_CTRL, {28'h0, ctl}, q);
    bus(8'h4, 8'h0, 8'h0);
    core(1'b0, 1'b1, b + 2048, 3'h6);
    bus(8'h0, 8'h0, 8'h1);
    $display("test mini done");
    for (k = 0; k < 48; k = k + 1) begin
      r = $random(seed);
      if (k % 8 == 0) begin
        ctl = {r[13], r[12], r[11:10]};
        wb(1'b1, `CCPL_ADR_CTRL, {28'h0, ctl}, q);
      end
      b = 32'h0040_0000 + {r[15:13], r[9:5], r[20:18], 2'h0};
      core(r[0], r[1], b, r[4:2]);
      chk(rsp_cache_o, exp_c(r[0], r[4:2], ctl[1:0]));
    end
    $display("test random done");
    tally_and_finish;
  end
endmodule
